// ===== design/abf_pkg.sv
/*
  Shared constants for the asynchronous byte FIFO port: data width, buffer
  depth, clock period and reset levels of the flags and strobe synchronisers.
  Assumes a single 125 MHz clock and an active-low asynchronous reset.
*/
package abf_pkg;

  localparam int ABF_DATA_W     = 8;
  localparam int ABF_FIFO_DEPTH = 16;

  localparam real ABF_CLK_PERIOD_NS = 8.0;

  // Reset levels of the flags: both read as "not ready" until released.
  localparam logic ABF_RX_AVAIL_N_RST = 1'b1;
  localparam logic ABF_TX_SPACE_N_RST = 1'b1;
  localparam logic ABF_STROBE_IDLE    = 1'b1;

endpackage

// ===== design/abf_fifo.sv
/*
  Synchronous first-in first-out buffer with valid/ready on both sides and
  a registered read word that always shows the oldest entry.
  Assumes DEPTH is a power of two and both sides run on clk.
*/
`timescale 1ns/1ps
`default_nettype none

module abf_fifo #(
  parameter int WIDTH = abf_pkg::ABF_DATA_W,
  parameter int DEPTH = abf_pkg::ABF_FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  import abf_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = DEPTH[AW:0];

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW-1:0]    rdNext;
  logic [AW:0]      count_q;
  logic [WIDTH-1:0] outData_q;
  logic             push;
  logic             pop;

  assign inReady  = (count_q != FULL_COUNT);
  assign outValid = (count_q != '0);
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;
  assign rdNext   = pop ? rdPtr_q + 1'b1 : rdPtr_q;
  assign outData  = outData_q;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  // A word written into the slot about to be shown bypasses the array, so
  // the read register is current in the same cycle as the count.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      outData_q <= '0;
    end else if (push && (wrPtr_q == rdNext)) begin
      outData_q <= inData;
    end else begin
      outData_q <= mem[rdNext];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      rdPtr_q <= rdNext;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= '0;
    end else begin
      case ({push, pop})
        2'b10:   count_q <= count_q + 1'b1;
        2'b01:   count_q <= count_q - 1'b1;
        default: count_q <= count_q;
      endcase
    end
  end

endmodule

`default_nettype wire

// ===== design/abf_port.sv
/*
  Device end of the asynchronous byte FIFO port: pin strobes and flags on
  one side, USB-facing byte streams and wake/flush requests on the other.
  Assumes the pins are asynchronous to clk; each passes two flip-flops
  first. The USB core supplies the power-enabled level, the remote wake
  option and a pulse for each Bulk-IN request, all on clk.
*/
`timescale 1ns/1ps
`default_nettype none

module abf_port (
  input  wire logic                             clk,
  input  wire logic                             reset_n,
  // Pin side.
  input  wire logic                             rdStrobeN,
  input  wire logic                             wrStrobeN,
  input  wire logic                             send_now_wake_n,
  input  wire logic [abf_pkg::ABF_DATA_W-1:0]   fifo_data_bus_in,
  output logic      [abf_pkg::ABF_DATA_W-1:0]   fifo_data_bus_out,
  output logic                                  fifo_data_bus_oe,
  output logic                                  rx_avail_n,
  output logic                                  rx_avail_n_oe,
  output logic                                  tx_space_n,
  output logic                                  tx_space_n_oe,
  // USB core side.
  input  wire logic                             power_enabled_n,
  input  wire logic                             remoteWakeEnable,
  input  wire logic                             bulkInRequest,
  input  wire logic                             usbRxValid,
  output logic                                  usbRxReady,
  input  wire logic [abf_pkg::ABF_DATA_W-1:0]   usbRxData,
  output logic                                  usbTxValid,
  input  wire logic                             usbTxReady,
  output logic      [abf_pkg::ABF_DATA_W-1:0]   usbTxData,
  output logic                                  flushPending,
  output logic                                  resumeRequest
);
  import abf_pkg::*;

  logic                  rdSync1_q;
  logic                  rdSync2_q;
  logic                  rdPrev_q;
  logic                  wrSync1_q;
  logic                  wrSync2_q;
  logic                  wrPrev_q;
  logic                  wakeSync1_q;
  logic                  wakeSync2_q;
  logic                  wakePrev_q;
  logic [ABF_DATA_W-1:0] dataSync1_q;
  logic [ABF_DATA_W-1:0] dataSync2_q;

  logic                  rdFall;
  logic                  rdRise;
  logic                  wrFall;
  logic                  wakeFall;

  logic                  rxValid;
  logic [ABF_DATA_W-1:0] rxData;
  logic                  rxPop;
  logic                  txReady;
  logic                  txPush;

  logic [ABF_DATA_W-1:0] busData_q;
  logic                  busOe_q;
  logic                  rxAvailN_q;
  logic                  txSpaceN_q;
  logic                  flagsOe_q;
  logic                  flushPending_q;
  logic                  resumeRequest_q;

  // Two-stage synchronisers; logic reads the second stage and its edge-detect copy, never the first stage.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdSync1_q <= ABF_STROBE_IDLE;
      rdSync2_q <= ABF_STROBE_IDLE;
      rdPrev_q  <= ABF_STROBE_IDLE;
    end else begin
      rdSync1_q <= rdStrobeN;
      rdSync2_q <= rdSync1_q;
      rdPrev_q  <= rdSync2_q;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrSync1_q <= ABF_STROBE_IDLE;
      wrSync2_q <= ABF_STROBE_IDLE;
      wrPrev_q  <= ABF_STROBE_IDLE;
    end else begin
      wrSync1_q <= wrStrobeN;
      wrSync2_q <= wrSync1_q;
      wrPrev_q  <= wrSync2_q;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wakeSync1_q <= ABF_STROBE_IDLE;
      wakeSync2_q <= ABF_STROBE_IDLE;
      wakePrev_q  <= ABF_STROBE_IDLE;
    end else begin
      wakeSync1_q <= send_now_wake_n;
      wakeSync2_q <= wakeSync1_q;
      wakePrev_q  <= wakeSync2_q;
    end
  end

  // The data bus shares the strobe's synchroniser depth, so the byte seen
  // at the detected write edge is the one present when the strobe fell.
  // The outside party must therefore hold data stable around that edge.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dataSync1_q <= '0;
      dataSync2_q <= '0;
    end else begin
      dataSync1_q <= fifo_data_bus_in;
      dataSync2_q <= dataSync1_q;
    end
  end

  assign rdFall   = rdPrev_q & ~rdSync2_q;
  assign rdRise   = ~rdPrev_q & rdSync2_q;
  assign wrFall   = wrPrev_q & ~wrSync2_q;
  assign wakeFall = wakePrev_q & ~wakeSync2_q;

  // Receive path: USB core fills, the read strobe drains.
  assign rxPop = rdRise & rxValid;

  abf_fifo #(
    .WIDTH (ABF_DATA_W),
    .DEPTH (ABF_FIFO_DEPTH)
  ) rxFifo (
    .clk      (clk),
    .reset_n  (reset_n),
    .inValid  (usbRxValid),
    .inReady  (usbRxReady),
    .inData   (usbRxData),
    .outValid (rxValid),
    .outReady (rxPop),
    .outData  (rxData)
  );

  // Transmit path: the write strobe fills, the USB core drains. A write
  // while full is dropped; the flag told the outside party to wait.
  assign txPush = wrFall & txReady;

  abf_fifo #(
    .WIDTH (ABF_DATA_W),
    .DEPTH (ABF_FIFO_DEPTH)
  ) txFifo (
    .clk      (clk),
    .reset_n  (reset_n),
    .inValid  (txPush),
    .inReady  (txReady),
    .inData   (dataSync2_q),
    .outValid (usbTxValid),
    .outReady (usbTxReady),
    .outData  (usbTxData)
  );

  // The byte is latched at the falling edge and held for the whole low
  // phase, so a push from the USB side cannot change it under the reader.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busData_q <= '0;
    end else if (rdFall) begin
      busData_q <= rxData;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busOe_q <= 1'b0;
    end else begin
      busOe_q <= ~rdSync2_q;
    end
  end

  // Receive-available flag: forced high for the cycle after a rising read
  // strobe, so every read shows a high pulse even when more data waits.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rxAvailN_q <= ABF_RX_AVAIL_N_RST;
    end else if (rdRise) begin
      rxAvailN_q <= 1'b1;
    end else begin
      rxAvailN_q <= ~rxValid;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      txSpaceN_q <= ABF_TX_SPACE_N_RST;
    end else begin
      txSpaceN_q <= ~txReady;
    end
  end

  // Flags float while reset is held and are driven from the first edge
  // after its release.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flagsOe_q <= 1'b0;
    end else begin
      flagsOe_q <= 1'b1;
    end
  end

  // Send-now/wake strobe. A new strobe wins over the Bulk-IN clear in the
  // same cycle, so a request is never lost.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flushPending_q <= 1'b0;
    end else if (wakeFall && !power_enabled_n) begin
      flushPending_q <= 1'b1;
    end else if (bulkInRequest) begin
      flushPending_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      resumeRequest_q <= 1'b0;
    end else begin
      resumeRequest_q <= wakeFall & power_enabled_n & remoteWakeEnable;
    end
  end

  assign fifo_data_bus_out = busData_q;
  assign fifo_data_bus_oe  = busOe_q;
  assign rx_avail_n        = rxAvailN_q;
  assign rx_avail_n_oe     = flagsOe_q;
  assign tx_space_n        = txSpaceN_q;
  assign tx_space_n_oe     = flagsOe_q;
  assign flushPending      = flushPending_q;
  assign resumeRequest     = resumeRequest_q;

endmodule

`default_nettype wire

// ===== verification/abf_port_chk.sv
/*
  Checker for abf_port: strobe, flag and wake timing at the top ports.
  Assumes pins are synchronised with two flops before any reaction.
*/
`timescale 1ns/1ps
`default_nettype none
module abf_port_chk (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic rdStrobeN,
  input wire logic wrStrobeN,
  input wire logic send_now_wake_n,
  input wire logic fifo_data_bus_oe,
  input wire logic rx_avail_n,
  input wire logic rx_avail_n_oe,
  input wire logic tx_space_n,
  input wire logic tx_space_n_oe,
  input wire logic power_enabled_n,
  input wire logic remoteWakeEnable,
  input wire logic usbTxValid,
  input wire logic flushPending,
  input wire logic resumeRequest
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Reset itself is the cause here, so this one must not be disabled by it.
  property p_rst_float;
    disable iff (1'b0) !reset_n |-> !tx_space_n_oe && !rx_avail_n_oe;
  endproperty
  a_rst_float: assert property (p_rst_float) else $error("flag driven in reset");
  property p_flag_on;
    $rose(reset_n) |-> ##1 tx_space_n_oe && rx_avail_n_oe;
  endproperty
  a_flag_on: assert property (p_flag_on) else $error("flag not driven after reset");
  property p_bus_on;
    $rose(fifo_data_bus_oe) |-> !$past(rdStrobeN) && !$past(rdStrobeN, 2);
  endproperty
  a_bus_on: assert property (p_bus_on) else $error("bus driven without read");
  property p_bus_off;
    $rose(rdStrobeN) |-> ##[1:6] !fifo_data_bus_oe;
  endproperty
  a_bus_off: assert property (p_bus_off) else $error("bus kept after read");
  property p_rx_hi;
    $rose(rdStrobeN) |-> ##[1:6] rx_avail_n;
  endproperty
  a_rx_hi: assert property (p_rx_hi) else $error("rx flag not raised");
  property p_wr_take;
    $fell(wrStrobeN) && !tx_space_n |-> ##[1:6] usbTxValid;
  endproperty
  a_wr_take: assert property (p_wr_take) else $error("write not taken");
  property p_full;
    tx_space_n && tx_space_n_oe |-> usbTxValid;
  endproperty
  a_full: assert property (p_full) else $error("tx flag high while empty");
  property p_resume;
    $fell(send_now_wake_n) && power_enabled_n && remoteWakeEnable |-> ##[1:6] resumeRequest;
  endproperty
  a_resume: assert property (p_resume) else $error("no resume request");
  property p_res_only;
    resumeRequest |-> power_enabled_n && remoteWakeEnable && !$past(resumeRequest);
  endproperty
  a_res_only: assert property (p_res_only) else $error("bad resume request");
  property p_flush;
    $fell(send_now_wake_n) && !power_enabled_n |-> ##[1:6] flushPending;
  endproperty
  a_flush: assert property (p_flush) else $error("flush not set");
  c_read: cover property ($rose(fifo_data_bus_oe));
  c_full: cover property (tx_space_n && tx_space_n_oe);
  c_resume: cover property (resumeRequest);
  c_flush: cover property ($rose(flushPending));
endmodule
bind abf_port abf_port_chk i_abf_port_chk (.clk, .reset_n, .rdStrobeN, .wrStrobeN,
  .send_now_wake_n, .fifo_data_bus_oe, .rx_avail_n, .rx_avail_n_oe, .tx_space_n,
  .tx_space_n_oe, .power_enabled_n, .remoteWakeEnable, .usbTxValid, .flushPending,
  .resumeRequest);
`default_nettype wire

// ===== verification/abf_mcu.sv
/*
  Behavioural outside party driving the strobe pins and the data bus.
  Assumes it is called from the bench right after a rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module abf_mcu (
  input  wire logic                         clk,
  input  wire logic [abf_pkg::ABF_DATA_W-1:0] devData,
  input  wire logic                         devOe,
  input  wire logic                         rxAvailN,
  input  wire logic                         txSpaceN,
  output logic                              rdStrobeN,
  output logic                              wrStrobeN,
  output logic                              wakeN,
  output logic      [abf_pkg::ABF_DATA_W-1:0] busLevel
);
  import abf_pkg::*;
  logic [ABF_DATA_W-1:0] wrData = '0;
  logic [ABF_DATA_W-1:0] lastQ = '0;
  logic                  drive = 1'b0;
  initial begin
    rdStrobeN = 1'b1;
    wrStrobeN = 1'b1;
    wakeN = 1'b1;
  end
  // A released bus shows the inverse of its last level, so stale data never matches.
  assign busLevel = devOe ? devData : (drive ? wrData : ~lastQ);
  always @(posedge clk) lastQ <= busLevel;
  task automatic do_read(output logic [ABF_DATA_W-1:0] d);
    for (int i = 0; i < 64 && rxAvailN !== 1'b0; i++) @(posedge clk);
    rdStrobeN <= 1'b0;
    repeat (4) @(posedge clk);
    d = busLevel;
    rdStrobeN <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  task automatic do_write(input logic [ABF_DATA_W-1:0] b);
    for (int i = 0; i < 64 && txSpaceN !== 1'b0; i++) @(posedge clk);
    wrData <= b;
    drive <= 1'b1;
    @(posedge clk);
    wrStrobeN <= 1'b0;
    repeat (4) @(posedge clk);
    wrStrobeN <= 1'b1;
    // The bus is let go some edges before the task returns, so a following
    // write never assigns the drive flag twice in one time step.
    repeat (3) @(posedge clk);
    drive <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic do_wake();
    wakeN <= 1'b0;
    repeat (4) @(posedge clk);
    wakeN <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ===== verification/async_byte_fifo_port_tb.sv
/*
  Self-checking bench for abf_port with a model of the outside party.
  Assumes the USB core side is played by the bench itself.
*/
`timescale 1ns/1ps
`default_nettype none
module async_byte_fifo_port_tb;
  import abf_pkg::*;
  logic clk = 1'b0, reset_n, power_enabled_n = 1'b0, remoteWakeEnable = 1'b0;
  logic bulkInRequest = 1'b0, usbRxValid = 1'b0, usbTxReady = 1'b0;
  logic [ABF_DATA_W-1:0] usbRxData = '0, fifo_data_bus_in, fifo_data_bus_out, usbTxData;
  logic rdStrobeN, wrStrobeN, send_now_wake_n, fifo_data_bus_oe, rx_avail_n, rx_avail_n_oe;
  logic tx_space_n, tx_space_n_oe, usbRxReady, usbTxValid, flushPending, resumeRequest;
  int n_fail = 0, checks_done = 0, cyc = 0, nRes = 0;
  abf_port i_abf_port (.clk, .reset_n, .rdStrobeN, .wrStrobeN, .send_now_wake_n,
    .fifo_data_bus_in, .fifo_data_bus_out, .fifo_data_bus_oe, .rx_avail_n, .rx_avail_n_oe,
    .tx_space_n, .tx_space_n_oe, .power_enabled_n, .remoteWakeEnable, .bulkInRequest,
    .usbRxValid, .usbRxReady, .usbRxData, .usbTxValid, .usbTxReady, .usbTxData,
    .flushPending, .resumeRequest);
  abf_mcu i_abf_mcu (.clk, .devData(fifo_data_bus_out), .devOe(fifo_data_bus_oe),
    .rxAvailN(rx_avail_n), .txSpaceN(tx_space_n), .rdStrobeN, .wrStrobeN,
    .wakeN(send_now_wake_n), .busLevel(fifo_data_bus_in));
  initial forever #4 clk = ~clk;
  always @(posedge clk) if (resumeRequest === 1'b1) nRes++;
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Fills the receive buffer past its depth while the outside party stalls, then drains it.
  task automatic t_rx();
    logic [7:0] d;
    int n;
    n = 0;
    usbRxValid <= 1'b1;
    for (int i = 0; i < 17; i++) begin
      usbRxData <= 8'ha0 + 8'(i);
      @(negedge clk);
      if (usbRxReady === 1'b1) n++;
      @(posedge clk);
    end
    usbRxValid <= 1'b0;
    chk("rx accepted", 8'd16, 8'(n));
    repeat (3) @(posedge clk);
    for (int i = 0; i < 16; i++) begin
      chk("rx_avail_n waiting", 8'h0, rx_avail_n);
      i_abf_mcu.do_read(d);
      chk("read byte", 8'ha0 + 8'(i), d);
    end
    chk("rx_avail_n empty", 8'h1, rx_avail_n);
  endtask
  task automatic t_tx();
    for (int i = 0; i < 16; i++) i_abf_mcu.do_write(8'h50 + 8'(i));
    repeat (3) @(posedge clk);
    chk("tx_space_n full", 8'h1, tx_space_n);
    usbTxReady <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      @(negedge clk);
      chk("tx valid", 8'h1, usbTxValid);
      chk("tx byte", 8'h50 + 8'(i), usbTxData);
      @(posedge clk);
    end
    usbTxReady <= 1'b0;
    repeat (3) @(posedge clk);
    chk("tx_space_n free", 8'h0, tx_space_n);
  endtask
  task automatic t_wake(input logic pe, input logic we, input logic [7:0] r, input logic f);
    power_enabled_n <= pe;
    remoteWakeEnable <= we;
    @(posedge clk);
    nRes = 0;
    i_abf_mcu.do_wake();
    chk("resume pulses", r, 8'(nRes));
    chk("flushPending", 8'(f), flushPending);
    bulkInRequest <= 1'b1;
    @(posedge clk);
    bulkInRequest <= 1'b0;
    repeat (2) @(posedge clk);
    chk("flushPending cleared", 8'h0, flushPending);
  endtask
  // A Bulk-IN request in the very cycle the strobe is detected must not lose the new request.
  task automatic t_flush_race();
    power_enabled_n <= 1'b0;
    @(posedge clk);
    fork
      i_abf_mcu.do_wake();
      begin
        repeat (2) @(posedge clk);
        bulkInRequest <= 1'b1;
        @(posedge clk);
        bulkInRequest <= 1'b0;
      end
    join
    chk("flushPending set wins", 8'h1, flushPending);
    bulkInRequest <= 1'b1;
    @(posedge clk);
    bulkInRequest <= 1'b0;
    repeat (2) @(posedge clk);
    chk("flushPending cleared", 8'h0, flushPending);
  endtask
  initial begin
    // A scheduled update at time zero gives the flops a reset edge to act on.
    reset_n <= 1'b0;
    repeat (5) @(posedge clk);
    chk("tx flag oe in reset", 8'h0, tx_space_n_oe);
    chk("rx flag oe in reset", 8'h0, rx_avail_n_oe);
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("tx flag oe after reset", 8'h1, tx_space_n_oe);
    chk("rx flag oe after reset", 8'h1, rx_avail_n_oe);
    chk("tx_space_n idle", 8'h0, tx_space_n);
    chk("rx_avail_n idle", 8'h1, rx_avail_n);
    t_rx();
    t_tx();
    t_wake(1'b1, 1'b1, 8'h1, 1'b0);
    t_wake(1'b1, 1'b0, 8'h0, 1'b0);
    t_wake(1'b0, 1'b1, 8'h0, 1'b1);
    t_flush_race();
    close_out();
  end
  // About 450 cycles are needed; the ceiling leaves wide margin.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      close_out();
    end
  end
endmodule
`default_nettype wire
